/* File: hw/spc_dev.sv */
// Device end: decode, power states, masking, strobed data
`timescale 1ns/100ps

// Contract
// - Row address with open, column with access
// - Bit ten on access closes row afterwards
// - Bit ten on close: one or all
// - Three bank bits pick one of eight
// - Mode load: address is code, bank picks
// - On-the-fly chop: bit twelve low chops
// - Inputs taken at rising clock crossing
// - Clock gate low picks power-down kind
// - Clock gate synchronous except self refresh exit
// - Power-down and self refresh disable inputs; termination enable is still sampled in power-down
// - Chip select high masks every command
// - Command from four strobes, same cycle
// - Lower mask high drops lower byte
// - Termination only on configured balls, if enabled
// - x8 termination strobe disables write mask
// - Read strobe edge aligned, write centred
// - Reset pin acts without the clock
// - Data four, eight or sixteen bits wide
// - Spare balls become upper x8 bits; lanes outside the organisation stay unused balls
// - Upper mask high drops upper byte
module spc_dev
  import spc_pkg::*;
#(
  parameter spc_org_t ORG = ORG_X16
)
(
  input  wire logic  clock_i,
  input  wire logic  rst_n_i,
  spc_if.dev         pins,
  output logic [3:0] pwr_state_o,
  output logic [7:0] open_banks_o
);

  // ********************************
  // Types and storage
  // ********************************
  typedef enum logic [3:0] {
    P_ON = 4'h1, P_APD = 4'h2, P_PPD = 4'h4, P_SREF = 4'h8
  } spc_pwr_t;

  spc_pwr_t          pwr_q;
  logic              rst_q;
  logic              ck_d_q;
  logic [1:0]        stb_d_q;
  logic [7:0]        open_q;
  logic [ADDR_W-1:0] row_q  [8];
  logic [ADDR_W-1:0] mode_q [MODE_REGS];
  logic [DQ_W-1:0]   mem_q  [MEM_DEPTH];
  logic [3:0]        wr_left_q;
  logic [3:0]        rd_left_q;
  logic [BANK_W-1:0] bst_ba_q;
  logic [2:0]        bst_col_q;

  // Lanes outside the organisation stay unused balls
  localparam logic [DQ_W-1:0] LANES = spc_lanes(ORG);

  // ********************************
  // Reset
  // ********************************
  // Link reset acts at once; local reset waits an edge
  always_ff @(posedge clock_i or negedge pins.reset_n)
    if (!pins.reset_n)
      rst_q <= 1'b0;
    else
      rst_q <= rst_n_i;

  wire logic arst_n = pins.reset_n && rst_q;

  // ********************************
  // Pin sampling and command decode
  // ********************************
  // Rising crossing: true clock goes high while the complement is low
  wire logic rise = pins.ck && !ck_d_q && !pins.clock_complement;
  wire logic live = pwr_q == P_ON;
  // Decode needs select low, gate high, awake
  wire logic cmd_ok = rise && live && pins.cke && !pins.cs_n;
  wire logic [2:0] cmd = {pins.ras_n, pins.cas_n, pins.we_n};
  wire logic ap = pins.addr[AP_BIT];
  wire logic wtog = pins.stb[0] ^ stb_d_q[0];
  wire logic [5:0] bidx = {bst_ba_q, bst_col_q};

  // Termination on when any level bit is set
  wire logic rtt_on = mode_q[1][MR1_RTT_A] || mode_q[1][MR1_RTT_B] || mode_q[1][MR1_RTT_C];
  wire logic termination_strobe_on = ORG == ORG_X8 && mode_q[1][MR1_TERMINATION_STROBE_BIT];

  // x8 loses masking to the termination strobe
  wire logic drop_lo = pins.mask[0] && !termination_strobe_on;
  wire logic drop_hi = ORG == ORG_X16 ? pins.mask[1] : 1'b0;

  // Clock history for crossing and strobe edge detect
  always_ff @(posedge clock_i or negedge arst_n)
    if (!arst_n)
    begin
      ck_d_q  <= 1'b0;
      stb_d_q <= 2'h0;
    end
    else
    begin
      ck_d_q  <= pins.ck;
      stb_d_q <= pins.stb;
    end

  // ********************************
  // Power state
  // ********************************
  // Only self refresh exit skips the crossing
  always_ff @(posedge clock_i or negedge arst_n)
    if (!arst_n)
      pwr_q <= P_ON;
    else
    begin
      case (pwr_q)
        P_ON:
          if (rise && !pins.cke)
          begin
            if (open_q != 8'h00)
              pwr_q <= P_APD;
            else if (!pins.cs_n && cmd == CMD_REF)
              pwr_q <= P_SREF;
            else
              pwr_q <= P_PPD;
          end
        P_APD, P_PPD:
          if (rise && pins.cke)
            pwr_q <= P_ON;
        P_SREF:
          if (pins.cke)
            pwr_q <= P_ON;
        default:
          pwr_q <= P_ON;
      endcase
    end

  // ********************************
  // Banks and mode registers
  // ********************************
  always_ff @(posedge clock_i or negedge arst_n)
    if (!arst_n)
    begin
      open_q <= 8'h00;
      for (int i = 0; i < 8; i++)
        row_q[i] <= 15'h0000;
      for (int i = 0; i < MODE_REGS; i++)
        mode_q[i] <= MODE_RST;
    end
    else if (cmd_ok)
    begin
      case (cmd)
        CMD_ACT:
        begin
          open_q[pins.ba] <= 1'b1;
          row_q[pins.ba]  <= pins.addr;
        end
        CMD_PRE:
          if (ap)
            open_q <= 8'h00;
          else
            open_q[pins.ba] <= 1'b0;
        CMD_RD, CMD_WR:
          // Auto close: the row is marked shut as the burst is accepted
          if (ap)
            open_q[pins.ba] <= 1'b0;
        CMD_MRS:
          // Only four mode registers; the top bank bit must be low
          if (!pins.ba[2])
            mode_q[pins.ba[1:0]] <= pins.addr;
        default:
          open_q <= open_q;
      endcase
    end

  // ********************************
  // Burst tracking
  // ********************************
  always_ff @(posedge clock_i or negedge arst_n)
    if (!arst_n)
    begin
      wr_left_q <= 4'h0;
      rd_left_q <= 4'h0;
      bst_ba_q  <= 3'h0;
      bst_col_q <= 3'h0;
    end
    else
    begin
      if (cmd_ok && (cmd == CMD_RD || cmd == CMD_WR))
      begin
        bst_ba_q  <= pins.ba;
        bst_col_q <= pins.addr[2:0];
        if (cmd == CMD_WR)
          wr_left_q <= spc_beats(mode_q[0][1:0], pins.addr[CHOP_BIT]);
        else
          rd_left_q <= spc_beats(mode_q[0][1:0], pins.addr[CHOP_BIT]);
      end
      else if (wr_left_q != 4'h0 && wtog)
      begin
        wr_left_q <= wr_left_q - 4'h1;
        bst_col_q <= bst_col_q + 3'h1;
      end
      else if (rd_left_q != 4'h0 && rise)
      begin
        rd_left_q <= rd_left_q - 4'h1;
        bst_col_q <= bst_col_q + 3'h1;
      end
    end

  // ********************************
  // Data array
  // ********************************
  // Small array wraps the column within the bank; rows share it
  always_ff @(posedge clock_i)
    if (wr_left_q != 4'h0 && wtog && !(cmd_ok && cmd == CMD_WR))
    begin
      // Beat is taken on the strobe edge, mask sampled with it
      if (!drop_lo)
        mem_q[bidx][7:0] <= pins.dq[7:0] & LANES[7:0];
      if (!drop_hi)
        mem_q[bidx][15:8] <= pins.dq[15:8] & LANES[15:8];
    end

  // ********************************
  // Read drive and termination
  // ********************************
  // Data and strobe change together, so the strobe is edge aligned
  always_ff @(posedge clock_i or negedge arst_n)
    if (!arst_n)
    begin
      pins.d_dq      <= 16'h0000;
      pins.d_dq_oe_n <= 1'b1;
      pins.d_stb     <= 2'h0;
      pins.d_stb_oe_n <= 1'b1;
    end
    else if (rise)
    begin
      if (rd_left_q != 4'h0 && !(cmd_ok && cmd == CMD_RD))
      begin
        pins.d_dq       <= mem_q[bidx] & LANES;
        pins.d_stb      <= ~pins.d_stb;
        pins.d_dq_oe_n  <= 1'b0;
        pins.d_stb_oe_n <= 1'b0;
      end
      else
      begin
        pins.d_dq_oe_n  <= 1'b1;
        pins.d_stb_oe_n <= 1'b1;
      end
    end

  // Termination input still heard in power-down, not in self refresh
  always_ff @(posedge clock_i or negedge arst_n)
    if (!arst_n)
    begin
      pins.term_dq            <= 16'h0000;
      pins.termination_strobe <= 1'b0;
    end
    else if (pwr_q == P_SREF)
    begin
      pins.term_dq            <= 16'h0000;
      pins.termination_strobe <= 1'b0;
    end
    else if (rise)
    begin
      pins.term_dq            <= (pins.termination_enable && rtt_on) ? LANES : 16'h0000;
      pins.termination_strobe <= pins.termination_enable && rtt_on && termination_strobe_on;
    end

  // Observation outputs
  assign pwr_state_o  = pwr_q;
  assign open_banks_o = open_q;

endmodule

/* File: pkg/spc_pkg.sv */
// Shared constants, types and helpers
package spc_pkg;

  // ********************************
  // Pin widths and command codes
  // ********************************
  localparam int ADDR_W    = 15;
  localparam int BANK_W    = 3;
  localparam int DQ_W      = 16;
  localparam int MEM_DEPTH = 64;
  localparam int BUF_DEPTH = 8;
  localparam int MODE_REGS = 4;
  // Command code is {row strobe, column strobe, write enable}, all active low
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR  = 3'h4;
  localparam logic [2:0] CMD_RD  = 3'h5;
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam int AP_BIT   = 10;
  localparam int CHOP_BIT = 12;

  // ********************************
  // Mode register fields
  // ********************************
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int MR1_TERMINATION_STROBE_BIT = 11;
  localparam int MR1_RTT_A    = 2;
  localparam int MR1_RTT_B    = 6;
  localparam int MR1_RTT_C    = 9;
  localparam logic [ADDR_W-1:0] MODE_RST = 15'h0000;
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam logic [3:0] BEATS_4 = 4'h4;

  // ********************************
  // Controller registers (APB)
  // ********************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_WBUF = 8'h40;
  localparam logic [7:0] REG_RBUF = 8'h80;
  localparam int CTRL_CMD_LO  = 0;
  localparam int CTRL_BA_LO   = 3;
  localparam int CTRL_CKE_BIT = 6;
  localparam int CTRL_ODT_BIT = 7;
  localparam int CTRL_DESEL   = 8;
  localparam int CTRL_OTF_BIT = 9;
  localparam int CTRL_RST_BIT = 10;
  localparam int CTRL_GO_BIT  = 31;
  localparam logic [10:0] CTRL_RST = 11'h047;

  // Organisation of the memory device
  typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} spc_org_t;

  // Data lanes that carry data for an organisation
  function automatic logic [DQ_W-1:0] spc_lanes(input spc_org_t org);
    spc_lanes = (org == ORG_X4) ? 16'h000f : (org == ORG_X8) ? 16'h00ff : 16'hffff;
  endfunction

  // Beats in a burst from the burst field and the chop select bit
  function automatic logic [3:0] spc_beats(input logic [1:0] bl, input logic chop);
    if (bl == BL_FIXED4)
      spc_beats = BEATS_4;
    else if (bl == BL_OTF && !chop)
      spc_beats = BEATS_4;
    else
      spc_beats = BEATS_8;
  endfunction

endpackage

/* File: pkg/spc_if.sv */
// Pin bundle between the memory controller and the memory device
`timescale 1ns/100ps
interface spc_if;
  logic              ck;
  logic              clock_complement;
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [2:0]        ba;
  logic [14:0]       addr;
  logic [1:0]        mask;
  logic              termination_enable;
  logic              reset_n;
  logic [15:0]       c_dq;
  logic              c_dq_oe_n;
  logic [1:0]        c_stb;
  logic              c_stb_oe_n;
  logic [15:0]       d_dq;
  logic              d_dq_oe_n;
  logic [1:0]        d_stb;
  logic              d_stb_oe_n;
  logic [15:0]       term_dq;
  logic              termination_strobe;
  logic [15:0]       dq;
  logic [1:0]        stb;

  // Wire level from the enables; an undriven bus reads low
  assign dq  = !c_dq_oe_n ? c_dq : (!d_dq_oe_n ? d_dq : 16'h0000);
  assign stb = !c_stb_oe_n ? c_stb : (!d_stb_oe_n ? d_stb : 2'h0);

  modport ctl (
    output ck, clock_complement, cke, cs_n, ras_n, cas_n, we_n, ba, addr, mask,
    output termination_enable, reset_n, c_dq, c_dq_oe_n, c_stb, c_stb_oe_n,
    input  dq, stb
  );
  modport dev (
    input  ck, clock_complement, cke, cs_n, ras_n, cas_n, we_n, ba, addr, mask,
    input  termination_enable, reset_n, dq, stb,
    output d_dq, d_dq_oe_n, d_stb, d_stb_oe_n, term_dq, termination_strobe
  );
endinterface

/* File: hw/spc_ctl.sv */
// Controller end: APB registers in, command and data pins out
`timescale 1ns/100ps
module spc_ctl
  import spc_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  spc_if.ctl               pins,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);

  // ********************************
  // State and storage
  // ********************************
  typedef enum logic [3:0] {
    C_IDLE = 4'h1, C_CMD = 4'h2, C_POST = 4'h4, C_DATA = 4'h8
  } spc_cst_t;

  spc_cst_t          st_q;
  logic [10:0]       ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [17:0]       wbuf_q [BUF_DEPTH];
  logic [DQ_W-1:0]   rbuf_q [BUF_DEPTH];
  logic [3:0]        beat_q;
  logic [3:0]        len_q;
  logic [1:0]        stb_d_q;
  logic              ck_q;
  logic              rd_q;

  wire logic access  = psel_i && penable_i;
  wire logic commit  = access && pready_o;
  wire logic go      = commit && pwrite_i && paddr_i == REG_CTRL && pwdata_i[CTRL_GO_BIT];
  wire logic toggled = pins.stb[0] ^ stb_d_q[0];
  wire logic [2:0] idx = paddr_i[4:2];

  // ********************************
  // APB slave
  // ********************************
  // One wait state: data is set up in the first access cycle
  always_ff @(posedge clock_i)
    if (!rst_n_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= access && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      if (access && !pready_o)
      begin
        if (paddr_i == REG_CTRL)
          prdata_o <= {21'h0, ctrl_q};
        else if (paddr_i == REG_ADDR)
          prdata_o <= {17'h0, addr_q};
        else if (paddr_i == REG_STAT)
          prdata_o <= {31'h0, st_q != C_IDLE};
        else if (paddr_i[7:5] == REG_WBUF[7:5] && paddr_i[1:0] == 2'h0)
          prdata_o <= {14'h0, wbuf_q[idx]};
        else if (paddr_i[7:5] == REG_RBUF[7:5] && paddr_i[1:0] == 2'h0)
          prdata_o <= {16'h0, rbuf_q[idx]};
        else
          pslverr_o <= 1'b1;
      end
    end

  // Register writes land at the edge that completes the access
  always_ff @(posedge clock_i)
    if (!rst_n_i)
    begin
      ctrl_q <= CTRL_RST;
      addr_q <= 15'h0000;
    end
    else if (commit && pwrite_i)
    begin
      // Control changes while busy are refused so pins stay stable
      if (paddr_i == REG_CTRL && st_q == C_IDLE)
        ctrl_q <= pwdata_i[10:0];
      else if (paddr_i == REG_ADDR && st_q == C_IDLE)
        addr_q <= pwdata_i[ADDR_W-1:0];
    end

  // Write buffer, no reset needed: software fills it before use
  always_ff @(posedge clock_i)
    if (commit && pwrite_i && paddr_i[7:5] == REG_WBUF[7:5])
      wbuf_q[idx] <= pwdata_i[17:0];

  // ********************************
  // Link clock and level pins
  // ********************************
  // Link clock is half clock_i; pins move while ck is high
  always_ff @(posedge clock_i)
    if (!rst_n_i)
    begin
      ck_q                    <= 1'b0;
      pins.ck                 <= 1'b0;
      pins.clock_complement   <= 1'b1;
      pins.reset_n            <= 1'b0;
      pins.cke                <= 1'b0;
      pins.termination_enable <= 1'b0;
      stb_d_q                 <= 2'h0;
    end
    else
    begin
      ck_q                    <= !ck_q;
      pins.ck                 <= !ck_q;
      pins.clock_complement   <= ck_q;
      pins.reset_n            <= !ctrl_q[CTRL_RST_BIT];
      stb_d_q                 <= pins.stb;
      if (ck_q)
      begin
        pins.cke                <= ctrl_q[CTRL_CKE_BIT];
        pins.termination_enable <= ctrl_q[CTRL_ODT_BIT];
      end
    end

  // ********************************
  // Command and data sequencer
  // ********************************
  always_ff @(posedge clock_i)
    if (!rst_n_i)
    begin
      st_q            <= C_IDLE;
      pins.cs_n       <= 1'b1;
      {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_NOP;
      pins.ba         <= 3'h0;
      pins.addr       <= 15'h0000;
      pins.mask       <= 2'h0;
      pins.c_dq       <= 16'h0000;
      pins.c_dq_oe_n  <= 1'b1;
      pins.c_stb      <= 2'h0;
      pins.c_stb_oe_n <= 1'b1;
      beat_q          <= 4'h0;
      len_q           <= BEATS_8;
      rd_q            <= 1'b0;
    end
    else
    begin
      case (st_q)
        C_IDLE:
          if (go)
            st_q <= C_CMD;
        C_CMD:
          if (ck_q)
          begin
            // Command, bank and address share one link cycle
            pins.cs_n <= ctrl_q[CTRL_DESEL];
            {pins.ras_n, pins.cas_n, pins.we_n} <= ctrl_q[2:0];
            pins.ba   <= ctrl_q[5:3];
            pins.addr <= addr_q;
            len_q     <= spc_beats({1'b0, ctrl_q[CTRL_OTF_BIT]}, addr_q[CHOP_BIT]);
            rd_q      <= ctrl_q[2:0] == CMD_RD;
            beat_q    <= 4'h0;
            st_q      <= C_POST;
          end
        C_POST:
          if (ck_q)
          begin
            {pins.ras_n, pins.cas_n, pins.we_n} <= CMD_NOP;
            if (pins.we_n == 1'b0 && pins.cas_n == 1'b0 && pins.ras_n == 1'b1)
            begin
              pins.c_dq       <= wbuf_q[0][15:0];
              pins.mask       <= wbuf_q[0][17:16];
              pins.c_dq_oe_n  <= 1'b0;
              pins.c_stb_oe_n <= 1'b0;
              st_q            <= C_DATA;
            end
            else if (rd_q && !pins.cs_n)
              st_q <= C_DATA;
            else
              st_q <= C_IDLE;
          end
        C_DATA:
          if (rd_q)
          begin
            // Read beats are taken on each strobe edge the device makes
            if (toggled && pins.c_dq_oe_n)
            begin
              rbuf_q[beat_q[2:0]] <= pins.dq;
              beat_q <= beat_q + 4'h1;
              if (beat_q + 4'h1 == len_q)
                st_q <= C_IDLE;
            end
          end
          else if (!ck_q)
          begin
            // Strobe edge in the middle of each write beat
            pins.c_stb <= ~pins.c_stb;
            beat_q     <= beat_q + 4'h1;
          end
          else if (beat_q == len_q)
          begin
            pins.c_dq_oe_n  <= 1'b1;
            pins.c_stb_oe_n <= 1'b1;
            pins.mask       <= 2'h0;
            st_q            <= C_IDLE;
          end
          else
          begin
            pins.c_dq <= wbuf_q[beat_q[2:0]][15:0];
            pins.mask <= wbuf_q[beat_q[2:0]][17:16];
          end
        default:
          st_q <= C_IDLE;
      endcase
    end

endmodule

/* File: sim/spc_sva.sv */
// Pin assertions between the two ends
`timescale 1ns/100ps
module spc_sva
  import spc_pkg::*;
(
  input logic        clock_i,
  input logic        rst_n_i,
  input logic        ck,
  input logic        clock_complement,
  input logic        cke,
  input logic        cs_n,
  input logic        ras_n,
  input logic        cas_n,
  input logic        we_n,
  input logic [2:0]  ba,
  input logic [14:0] addr,
  input logic        termination_enable,
  input logic [15:0] term_dq,
  input logic [15:0] d_dq,
  input logic        c_dq_oe_n,
  input logic        d_dq_oe_n,
  input logic [1:0]  c_stb,
  input logic [1:0]  d_stb
);
  // ************************
  // Link relations
  // ************************
  // One clock domain
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  property p_ck_pair; clock_complement == !ck; endproperty
  a_ck_pair: assert property (p_ck_pair) else $error("ck pair");
  // Pins settle a cycle before the crossing
  property p_cmd_hold; $rose(ck) |-> $stable({cs_n, ras_n, cas_n, we_n, ba, addr}); endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("cmd moved");
  property p_dq_one; c_dq_oe_n || d_dq_oe_n; endproperty
  a_dq_one: assert property (p_dq_one) else $error("two drivers");
  property p_rd_drive;
    $rose(ck) && !cs_n && cke && {ras_n, cas_n, we_n} == CMD_RD |-> ##[1:6] !d_dq_oe_n;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("no read data");
  property p_wr_drive;
    $rose(ck) && !cs_n && cke && {ras_n, cas_n, we_n} == CMD_WR |-> ##[1:6] !c_dq_oe_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("no write data");
  // Strobe moves mid write beat
  property p_wr_centre; $fell(c_dq_oe_n) |=> $changed(c_stb); endproperty
  a_wr_centre: assert property (p_wr_centre) else $error("wr strobe");
  property p_rd_edge; !d_dq_oe_n && $changed(d_dq) |-> $changed(d_stb); endproperty
  a_rd_edge: assert property (p_rd_edge) else $error("rd strobe");
  property p_term_off; $fell(termination_enable) |-> ##[1:4] term_dq == 16'h0000; endproperty
  a_term_off: assert property (p_term_off) else $error("term on");
  // Chopped burst: four beats of two cycles
  property p_burst; $fell(c_dq_oe_n) |-> !c_dq_oe_n [*8]; endproperty
  a_burst: assert property (p_burst) else $error("short burst");
endmodule

/* File: sim/spc_tb.sv */
// Self-checking bench for both ends
`timescale 1ns/100ps
module spc_tb
  import spc_pkg::*;
;
  // ************************
  // Signals and instances
  // ************************
  localparam logic [4:0]  F_CKE  = 5'h01;
  localparam logic [4:0]  F_TERM = 5'h02;
  localparam logic [4:0]  F_DSL  = 5'h04;
  localparam logic [4:0]  F_OTF  = 5'h08;
  localparam logic [4:0]  F_RST  = 5'h10;
  localparam logic [14:0] A12    = 15'h1000;
  logic        clock_i;
  logic        rst_n_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [3:0]  pwr_state_o;
  logic [7:0]  open_banks_o;
  logic [31:0] rdata;
  logic        perr;
  int          n_mismatch;
  int          total_checks;
  spc_if spc_if_inst ();
  spc_ctl spc_ctl_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .pins(spc_if_inst),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  spc_dev #(.ORG(ORG_X16)) spc_dev_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .pins(spc_if_inst), .pwr_state_o(pwr_state_o), .open_banks_o(open_banks_o));
  spc_sva spc_sva_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .ck(spc_if_inst.ck),
    .clock_complement(spc_if_inst.clock_complement), .cke(spc_if_inst.cke),
    .cs_n(spc_if_inst.cs_n), .ras_n(spc_if_inst.ras_n), .cas_n(spc_if_inst.cas_n),
    .we_n(spc_if_inst.we_n), .ba(spc_if_inst.ba), .addr(spc_if_inst.addr),
    .termination_enable(spc_if_inst.termination_enable), .term_dq(spc_if_inst.term_dq),
    .d_dq(spc_if_inst.d_dq), .c_dq_oe_n(spc_if_inst.c_dq_oe_n),
    .d_dq_oe_n(spc_if_inst.d_dq_oe_n), .c_stb(spc_if_inst.c_stb), .d_stb(spc_if_inst.d_stb));
  // 10 MHz system clock
  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // ************************
  // Tasks
  // ************************
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic bail(input string what);
    n_mismatch++;
    $display("CHECK FAILED at %0t: %s timed out", $time, what);
    stop_test();
  endtask
  // One APB transfer; answer taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1)
    begin
      if (++n > 20) bail("bus wait");
      @(posedge clock_i);
    end
    rdata = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // Orders while busy are dropped, so poll
  task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [14:0] a,
                     input logic [4:0] f);
    int n = 0;
    apb(1'b1, REG_ADDR, {17'h0, a});
    apb(1'b1, REG_CTRL, {1'b1, 20'h0, f, b, c});
    apb(1'b0, REG_STAT, 32'h0);
    while (rdata[0] !== 1'b0)
    begin
      if (++n > 50) bail("command");
      apb(1'b0, REG_STAT, 32'h0);
    end
  endtask
  task automatic fill(input logic [15:0] base, input logic [15:0] m);
    for (int k = 0; k < 8; k++)
      apb(1'b1, REG_WBUF + 8'(4 * k), {14'h0, m[2*k +: 2], base + 16'(k)});
  endtask
  // Beats below nn new; masked bytes old
  task automatic rdchk(input logic [2:0] b, input logic [15:0] nb, input logic [15:0] ob,
                       input logic [15:0] m, input int nn, input string what);
    logic [15:0] e;
    cmd(CMD_RD, b, A12, F_CKE);
    for (int k = 0; k < 8; k++)
    begin
      e = (k < nn) ? nb + 16'(k) : ob + 16'(k);
      if (m[2*k]) e[7:0] = ob[7:0] + 8'(k);
      if (m[2*k+1]) e[15:8] = ob[15:8];
      apb(1'b0, REG_RBUF + 8'(4 * k), 32'h0);
      chk({16'h0, rdata[15:0]}, {16'h0, e}, what);
    end
  endtask
  task automatic wait_dev(input logic [3:0] p, input logic [7:0] o, input string what);
    int n = 0;
    while ((pwr_state_o !== p || open_banks_o !== o) && n < 20)
    begin
      @(posedge clock_i);
      n++;
    end
    if (n == 20) bail(what);
    chk({20'h0, pwr_state_o, open_banks_o}, {20'h0, p, o}, what);
  endtask
  // ************************
  // Test sequence
  // ************************
  initial
  begin
    n_mismatch = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = 8'h00;
    pwdata_i = 32'h0;
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0);
    chk({21'h0, rdata[10:0]}, {21'h0, CTRL_RST}, "ctrl reset");
    apb(1'b0, 8'hfc, 32'h0);
    chk({31'h0, perr}, 32'h1, "unmapped");
    wait_dev(4'h1, 8'h00, "reset");
    $display("test reset done");
    cmd(CMD_MRS, 3'h0, 15'h0001, F_CKE);
    cmd(CMD_MRS, 3'h1, 15'h0004, F_CKE);
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE | F_TERM);
    chk({16'h0, spc_if_inst.term_dq}, 32'hffff, "term on");
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE);
    chk({16'h0, spc_if_inst.term_dq}, 32'h0, "term off");
    fill(16'h3000, 16'h0000);
    cmd(CMD_WR, 3'h3, A12, F_CKE);
    fill(16'h5a00, 16'h0810);
    cmd(CMD_WR, 3'h3, A12, F_CKE);
    rdchk(3'h3, 16'h5a00, 16'h3000, 16'h0810, 8, "masked");
    fill(16'h1100, 16'h0000);
    cmd(CMD_WR, 3'h1, A12, F_CKE);
    fill(16'h7700, 16'h0000);
    cmd(CMD_WR, 3'h1, 15'h0000, F_CKE | F_OTF);
    rdchk(3'h1, 16'h7700, 16'h1100, 16'h0, 4, "chopped");
    fill(16'h9900, 16'h0000);
    cmd(CMD_WR, 3'h1, A12, F_CKE | F_DSL);
    rdchk(3'h1, 16'h7700, 16'h1100, 16'h0, 4, "desel");
    rdchk(3'h3, 16'h5a00, 16'h3000, 16'h0810, 8, "other bank");
    $display("test data done");
    cmd(CMD_ACT, 3'h2, 15'h0123, F_CKE);
    wait_dev(4'h1, 8'h04, "open 2");
    cmd(CMD_ACT, 3'h6, 15'h0456, F_CKE);
    wait_dev(4'h1, 8'h44, "open 6");
    cmd(CMD_PRE, 3'h2, 15'h0000, F_CKE);
    wait_dev(4'h1, 8'h40, "close one");
    cmd(CMD_NOP, 3'h0, 15'h0, 5'h00);
    wait_dev(4'h2, 8'h40, "apd");
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE);
    wait_dev(4'h1, 8'h40, "pd exit");
    cmd(CMD_PRE, 3'h0, 15'h0400, F_CKE);
    wait_dev(4'h1, 8'h00, "close all");
    cmd(CMD_NOP, 3'h0, 15'h0, 5'h00);
    wait_dev(4'h4, 8'h00, "ppd");
    cmd(CMD_ACT, 3'h7, 15'h0, 5'h00);
    wait_dev(4'h4, 8'h00, "pd ignore");
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE);
    cmd(CMD_REF, 3'h0, 15'h0, 5'h00);
    wait_dev(4'h8, 8'h00, "sref");
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE);
    wait_dev(4'h1, 8'h00, "sref exit");
    cmd(CMD_ACT, 3'h4, 15'h0, F_CKE);
    cmd(CMD_WR, 3'h4, 15'h1400, F_CKE);
    wait_dev(4'h1, 8'h00, "auto close");
    $display("test power done");
    cmd(CMD_ACT, 3'h5, 15'h0, F_CKE);
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE | F_RST);
    wait_dev(4'h1, 8'h00, "link reset");
    cmd(CMD_NOP, 3'h0, 15'h0, F_CKE);
    $display("test link reset done");
    stop_test();
  end
endmodule
